// File: verilog/vds_pkg.sv
// shared constants and carriers for the decoder status and format registers
package vds_pkg;

	// register window and layout
	localparam int          VDS_WIN_BITS     = 12;
	localparam logic [9:0]  VDS_IDX_COND     = 10'h000;
	localparam logic [9:0]  VDS_IDX_FMT      = 10'h001;
	localparam logic [7:0]  VDS_COND_RST     = 8'h00;
	localparam logic [7:0]  VDS_FMT_RST      = 8'h58;
	localparam logic [7:0]  VDS_FMT_WMASK    = 8'h7f;

	// condition register bit positions
	localparam int VDS_B_SIGNAL_DETECTED  = 7;
	localparam int VDS_B_HLOCK = 6;
	localparam int VDS_B_FIELD = 5;
	localparam int VDS_B_L625  = 4;
	localparam int VDS_B_XTAL  = 3;
	localparam int VDS_B_PLL   = 2;
	localparam int VDS_B_LOVF  = 1;
	localparam int VDS_B_COVF  = 0;

	// detector counts
	localparam logic [5:0] VDS_NOSYNC_LINES = 6'd31;
	localparam logic [5:0] VDS_LOCK_LINES   = 6'd32;
	localparam logic [5:0] VDS_FMT_FIELDS   = 6'd32;

	// standard and crystal codes
	localparam logic [2:0] VDS_STD_AUTO  = 3'h0;
	localparam logic [2:0] VDS_STD_NTSCM = 3'h1;
	localparam logic [2:0] VDS_STD_PALB  = 3'h3;
	localparam logic [1:0] VDS_XT_AUTO   = 2'h3;

	// register access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [9:0]  idx;
		logic [3:0]  be;
		logic [31:0] wdata;
	} vds_req_s;

	// live video front-end status
	typedef struct packed {
		logic line_tick;
		logic sync_seen;
		logic hsync_in_win;
		logic field_even;
		logic field_tick;
		logic field_625;
		logic xtal_second;
		logic pll_unlock;
		logic luma_ovf;
		logic chroma_ovf;
	} vds_vid_s;

endpackage : vds_pkg

// File: verilog/vds_counter_filter.sv
// restarting consecutive-event filter that flips a flag after a run
`timescale 1ns/1ns
`default_nettype none
module vds_counter_filter import vds_pkg::*; #(
	parameter logic [5:0] RUN_SET = 6'd32,
	parameter logic [5:0] RUN_CLR = 6'd32
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	input  wire logic i_tick,
	input  wire logic i_hit,
	output logic      o_flag
);
	logic [5:0] cnt_q;
	logic       flag_q;
	wire        disagree = (i_hit != flag_q);
	wire [5:0]  limit    = flag_q ? RUN_CLR : RUN_SET;
	wire        reached  = disagree && (cnt_q + 6'd1 >= limit);

	// count consecutive ticks that disagree with the flag
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cnt_q  <= 6'h00;
			flag_q <= 1'b0;
		end else if (i_tick) begin
			cnt_q  <= (disagree && !reached) ? cnt_q + 6'd1 : 6'h00;
			if (reached)
				flag_q <= ~flag_q;
		end
	end

	assign o_flag = flag_q;
endmodule : vds_counter_filter
`default_nettype wire

// File: verilog/vds_regs.sv
// device condition and input standard register bank with status detectors
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - decode bank inside a 4KB window
// - register chosen by address bits 11:2
// - any byte enable mix is accepted
// - data on lane 0, upper lanes read zero
// - registers four bytes apart, others reserved
// - field registers switch on field parity
// - status resets zero except live bit 3, overflow flags sticky
// - presence drops after 31 syncless lines
// - lock needs 32 hits, drops after 32 misses
// - bit 5 shows current field parity
// - 625 flag changes after 32 fields
// - bit 3 shows crystal port used
// - pll unlock flag, cleared by write
// - converter overflows set sticky bits 1,0
// - format register resets 0x58, bit7 zero
// - bits 6:5 choose analog input
// - bits 4:3 choose crystal
// - bits 2:0 choose video standard
// - auto mode picks standard from line count
module vds_regs import vds_pkg::*; #(
	parameter bit ENHANCED = 1'b1
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_sel,
	input  wire vds_req_s    i_req,
	input  wire vds_vid_s    i_vid,
	output logic [31:0]      o_rdata,
	output logic             o_hit,
	output logic [1:0]       o_analog_input_choice,
	output logic [1:0]       o_crystal_choice,
	output logic             o_auto_crystal,
	output logic [2:0]       o_std_active,
	output logic             o_field_odd_bank
);
	logic [7:0] fmt_q;
	logic       lovf_q;
	logic       covf_q;
	logic       pll_q;
	logic       field_q;
	logic [5:0] nosync_q;
	logic       signal_detected_q;
	logic [31:0] rdata_q;
	logic       line_lock_flag;
	logic       line_count_625;

	// window select by the upper decoder
	wire sel_cond = i_sel && (i_req.idx == VDS_IDX_COND);
	wire sel_fmt  = i_sel && (i_req.idx == VDS_IDX_FMT);
	// any be mix; only lane 0 writes
	wire wr_lane0 = i_sel && i_req.wr && i_req.be[0];
	wire wr_cond  = wr_lane0 && sel_cond;
	wire wr_fmt   = wr_lane0 && sel_fmt;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			nosync_q <= 6'h00;
			signal_detected_q   <= 1'b0;
		end else if (i_vid.sync_seen) begin
			nosync_q <= 6'h00;
			signal_detected_q   <= 1'b1;
		end else if (i_vid.line_tick) begin
			if (nosync_q + 6'd1 >= VDS_NOSYNC_LINES)
				signal_detected_q <= 1'b0;
			if (nosync_q < VDS_NOSYNC_LINES)
				nosync_q <= nosync_q + 6'd1;
		end
	end

	vds_counter_filter #(
		.RUN_SET (VDS_LOCK_LINES),
		.RUN_CLR (VDS_LOCK_LINES)
	) u_lock (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_tick    (i_vid.line_tick),
		.i_hit     (i_vid.hsync_in_win),
		.o_flag    (line_lock_flag)
	);

	// line count decided after 32 fields
	vds_counter_filter #(
		.RUN_SET (VDS_FMT_FIELDS),
		.RUN_CLR (VDS_FMT_FIELDS)
	) u_line_count_625 (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_tick    (i_vid.field_tick),
		.i_hit     (i_vid.field_625),
		.o_flag    (line_count_625)
	);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			field_q <= 1'b0;
		else
			field_q <= i_vid.field_even;
	end

	// sticky overflow and pll unlock flags, set beats clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			lovf_q <= 1'b0;
			covf_q <= 1'b0;
			pll_q  <= 1'b0;
		end else begin
			lovf_q <= i_vid.luma_ovf
				|| (lovf_q && !(wr_cond && i_req.wdata[VDS_B_LOVF]));
			covf_q <= i_vid.chroma_ovf
				|| (covf_q && !(wr_cond && i_req.wdata[VDS_B_COVF]));
			pll_q  <= ENHANCED && (i_vid.pll_unlock
				|| (pll_q && !(wr_cond && i_req.wdata[VDS_B_PLL])));
		end
	end

	// format register, bit 7 held zero
	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			fmt_q <= VDS_FMT_RST;
		else if (wr_fmt)
			fmt_q <= i_req.wdata[7:0] & VDS_FMT_WMASK;
	end

	wire [7:0] cond_val = {signal_detected_q, line_lock_flag, field_q, line_count_625,
		i_vid.xtal_second, pll_q, lovf_q, covf_q};

	// lane 0 only; unused index reads zero
	wire [7:0] rd_byte = sel_cond ? cond_val : (sel_fmt ? fmt_q : 8'h00);

	// read data register
	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			rdata_q <= 32'h0000_0000;
		else if (i_sel && i_req.rd)
			rdata_q <= {24'h000000, i_req.be[0] ? rd_byte : 8'h00};
	end

	assign o_rdata = rdata_q;
	assign o_hit   = sel_cond || sel_fmt;

	// analog input; code 00 reserved on base part
	assign o_analog_input_choice = fmt_q[6:5];
	assign o_crystal_choice = fmt_q[4:3];
	assign o_auto_crystal   = (fmt_q[4:3] == VDS_XT_AUTO);
	// standard code; auto from line count
	assign o_std_active = (fmt_q[2:0] != VDS_STD_AUTO) ? fmt_q[2:0]
		: (line_count_625 ? VDS_STD_PALB : VDS_STD_NTSCM);
	// odd or even field bank select
	assign o_field_odd_bank = ~field_q;

	// assertions
	// bit 7 never set
	fmt_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!fmt_q[7]) else $error("format bit 7 set");
	lovf_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		lovf_q && !wr_cond |=> lovf_q) else $error("luma flag lost");
	covf_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_vid.chroma_ovf |=> covf_q) else $error("chroma flag not set");
	lane_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rdata_q[31:8] == 24'h000000) else $error("upper lane nonzero");
	upper_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_sel && i_req.wr && !i_req.be[0] |=> $stable(fmt_q))
		else $error("upper lane write took effect");
	signal_detected_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_vid.sync_seen |=> signal_detected_q) else $error("presence not set");
	auto_std_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		fmt_q[2:0] == VDS_STD_AUTO && line_count_625 |-> o_std_active == VDS_STD_PALB)
		else $error("auto standard wrong");
	field_trk_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		1'b1 |=> field_q == $past(i_vid.field_even)) else $error("field bit stale");
	pll_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_cond && i_req.wdata[VDS_B_PLL] && !i_vid.pll_unlock |=> !pll_q)
		else $error("pll flag not cleared");

	// named steps shared by the flag, read, format and detector checks below
	// each one is a single cycle condition so the properties stay short
	// a write that clears the luma flag with no new overflow
	sequence lovf_clr_s;
		wr_cond && i_req.wdata[VDS_B_LOVF] && !i_vid.luma_ovf;
	endsequence

	// a write that clears the chroma flag with no new overflow
	sequence covf_clr_s;
		wr_cond && i_req.wdata[VDS_B_COVF] && !i_vid.chroma_ovf;
	endsequence

	// a set chroma flag that no write clears this cycle
	sequence covf_keep_s;
		covf_q && !(wr_cond && i_req.wdata[VDS_B_COVF]);
	endsequence

	// a lane 0 read of the condition register
	sequence rd_cond_s;
		i_sel && i_req.rd && i_req.be[0] && sel_cond;
	endsequence

	// a lane 0 read of the format register
	sequence rd_fmt_s;
		i_sel && i_req.rd && i_req.be[0] && sel_fmt;
	endsequence

	// a read outside both registers or without lane 0
	sequence rd_empty_s;
		i_sel && i_req.rd && (!o_hit || !i_req.be[0]);
	endsequence

	// a syncless line that completes the silent run
	sequence silent_end_s;
		i_vid.line_tick && !i_vid.sync_seen && (nosync_q == VDS_NOSYNC_LINES - 6'd1);
	endsequence

	// a lane 0 write to the format register
	sequence fmt_wr_s;
		wr_fmt;
	endsequence

	lovf_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		lovf_clr_s |=> !lovf_q) else $error("luma flag not cleared");

	covf_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		covf_clr_s |=> !covf_q) else $error("chroma flag not cleared");

	covf_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		covf_keep_s |=> covf_q) else $error("chroma flag lost");

	lovf_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_vid.luma_ovf |=> lovf_q) else $error("luma flag not set");

	pll_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		ENHANCED && i_vid.pll_unlock |=> pll_q) else $error("pll flag not set");

	pll_base_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		ENHANCED || !pll_q) else $error("pll bit set on base part");

	pll_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pll_q && !(wr_cond && i_req.wdata[VDS_B_PLL]) |=> pll_q)
		else $error("pll flag lost");

	fmt_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		fmt_wr_s |=> fmt_q == ($past(i_req.wdata[7:0]) & VDS_FMT_WMASK))
		else $error("format write lost");

	rsvd_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_fmt && i_req.wdata[7] |=> !fmt_q[7]) else $error("format bit 7 stored");

	fmt_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!wr_fmt |=> $stable(fmt_q)) else $error("format changed without write");

	upper_cond_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_sel && i_req.wr && !i_req.be[0] && covf_q |=> covf_q)
		else $error("upper lane write cleared flag");

	rd_cond_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_cond_s |=> o_rdata[7:0] == $past(cond_val)) else $error("condition read wrong");

	rd_upper_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_cond_s |=> o_rdata[31:8] == 24'h000000) else $error("condition upper nonzero");

	rd_fmt_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_fmt_s |=> o_rdata[7:0] == $past(fmt_q)) else $error("format read wrong");

	rd_empty_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_empty_s |=> o_rdata == 32'h0000_0000) else $error("empty read nonzero");

	rd_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!(i_sel && i_req.rd) |=> $stable(o_rdata)) else $error("read data moved");

	hit_dec_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_hit == (i_sel && (i_req.idx == VDS_IDX_COND || i_req.idx == VDS_IDX_FMT)))
		else $error("hit decode wrong");

	signal_detected_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		silent_end_s |=> !signal_detected_q) else $error("presence not dropped");

	nosync_sat_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		nosync_q <= VDS_NOSYNC_LINES) else $error("silent count overrun");

	signal_detected_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		signal_detected_q && !i_vid.line_tick |=> signal_detected_q) else $error("presence dropped early");

	lock_step_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_vid.line_tick |=> $stable(line_lock_flag)) else $error("lock moved off line");

	l625_step_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_vid.field_tick |=> $stable(line_count_625)) else $error("line count moved");

	auto_525_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		fmt_q[2:0] == VDS_STD_AUTO && !line_count_625 |-> o_std_active == VDS_STD_NTSCM)
		else $error("auto 525 standard wrong");

	man_std_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		fmt_q[2:0] != VDS_STD_AUTO |-> o_std_active == fmt_q[2:0])
		else $error("manual standard wrong");

	xtal_live_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		cond_val[VDS_B_XTAL] == i_vid.xtal_second) else $error("crystal bit stale");

	bank_sel_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_field_odd_bank != field_q) else $error("field bank wrong");

	ain_map_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_analog_input_choice == fmt_q[6:5]) else $error("input choice wrong");

	xt_map_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_crystal_choice == fmt_q[4:3]) else $error("crystal choice wrong");

	auto_xt_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_auto_crystal == (o_crystal_choice == VDS_XT_AUTO)) else $error("auto crystal wrong");
endmodule : vds_regs
`default_nettype wire

// File: test/vds_video_model.sv
// behavioural video front end that feeds line and field events
`timescale 1ns/1ns
`default_nettype none
module vds_video_model import vds_pkg::*; (
	input  wire logic       i_clk_sys,
	input  wire logic       i_run,
	input  wire logic [4:0] i_lvl,
	input  wire logic [2:0] i_evt,
	output var  vds_vid_s   o_vid
);
	logic [1:0] cnt_q;
	logic       tick;
	// one line and field event every fourth cycle while running
	always_ff @(posedge i_clk_sys) begin
		cnt_q <= i_run ? cnt_q + 2'd1 : 2'd0;
	end
	assign tick = i_run & (cnt_q == 2'd3);
	// lvl is sync, in-window, 625, even, second crystal
	assign o_vid = {tick, tick & i_lvl[4], i_lvl[3], i_lvl[1], tick, i_lvl[2], i_lvl[0], i_evt};
endmodule : vds_video_model
`default_nettype wire

// File: test/tb_vds_regs.sv
// bench for the condition and input standard register bank
`timescale 1ns/1ns
`default_nettype none
module tb_vds_regs import vds_pkg::*;;
	logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, run = 1'b0;
	logic [4:0]  lvl = '0;
	logic [2:0]  evt = '0;
	vds_req_s    req = '0;
	vds_vid_s    vid;
	logic [31:0] rdata;
	logic        hit, auto_x, odd;
	logic [1:0]  ain, xt;
	logic [2:0]  std;
	int          mismatches = 0, n_compared = 0;
	always #5 clk = ~clk;
	vds_video_model vds_video_model_i (.i_clk_sys(clk), .i_run(run), .i_lvl(lvl),
		.i_evt(evt), .o_vid(vid));
	vds_regs #(.ENHANCED(1'b1)) vds_regs_i (.i_clk_sys(clk), .i_rst(rst), .i_sel(sel),
		.i_req(req), .i_vid(vid), .o_rdata(rdata), .o_hit(hit), .o_analog_input_choice(ain),
		.o_crystal_choice(xt), .o_auto_crystal(auto_x), .o_std_active(std),
		.o_field_odd_bank(odd));
	// compare one result and count it
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// one register cycle, held for a single edge
	task automatic acc(input logic w, input logic [9:0] ix, input logic [3:0] be,
		input logic [31:0] wd);
		@(posedge clk);
		sel <= 1'b1;
		req <= '{rd: !w, wr: w, idx: ix, be: be, wdata: wd};
		#1 chk("hit", 32'(ix < 10'd2), 32'(hit));
		@(posedge clk);
		sel <= 1'b0;
		req <= '0;
		#1;
	endtask : acc
	// full-lane read with expected value
	task automatic rd(input logic [9:0] ix, input logic [31:0] exp);
		acc(1'b0, ix, 4'hf, 32'h0);
		chk("rdata", exp, rdata);
	endtask : rd
	// run the front end for n line events
	task automatic ticks(input int n, input logic [4:0] l);
		@(posedge clk);
		run <= 1'b1;
		lvl <= l;
		repeat (4 * n) @(posedge clk);
		run <= 1'b0;
	endtask : ticks
	// verdict and end of run
	task automatic stop_test();
		if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(10'h0, 32'h0);
		rd(10'h1, 32'h58);
		chk("outs", 32'h173, {ain, xt, auto_x, std, odd});
		ticks(31, 5'b11100);
		rd(10'h0, 32'h80);
		ticks(1, 5'b11100);
		rd(10'h0, 32'hd0);
		chk("std", 32'h3, 32'(std));
		ticks(30, 5'b01111);
		rd(10'h0, 32'hf8);
		ticks(1, 5'b01111);
		rd(10'h0, 32'h78);
		chk("bank", 32'h0, 32'(odd));
		@(posedge clk) evt <= 3'h7;
		@(posedge clk) evt <= 3'h0;
		rd(10'h0, 32'h7f);
		acc(1'b1, 10'h0, 4'h1, 32'h02);
		rd(10'h0, 32'h7d);
		acc(1'b1, 10'h0, 4'h1, 32'h05);
		rd(10'h0, 32'h78);
		acc(1'b1, 10'h1, 4'h1, 32'hffff_ffff);
		rd(10'h1, 32'h7f);
		chk("outs", 32'h1fe, {ain, xt, auto_x, std, odd});
		acc(1'b1, 10'h1, 4'he, 32'h0);
		rd(10'h1, 32'h7f);
		acc(1'b1, 10'h2, 4'hf, 32'h0);
		// every input, crystal and standard code
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, 10'h1, 4'h1, 32'({c[1:0], ~c[1:0], c[2:0]}));
			chk("code", {c[1:0], ~c[1:0], &(~c[1:0]), (c == 0) ? 3'h3 : c[2:0]},
				{ain, xt, auto_x, std});
		end
		// lock and 625 drop after their miss runs
		ticks(31, 5'b00000);
		rd(10'h0, 32'h50);
		ticks(1, 5'b00000);
		rd(10'h0, 32'h00);
		acc(1'b1, 10'h1, 4'h1, 32'h58);
		chk("std", 32'h1, 32'(std));
		stop_test();
	end
endmodule : tb_vds_regs
`default_nettype wire
